// *** clock_gate_pkg.sv ***
// Constants for the peripheral clock-gating block: offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package clock_gate_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] RUN_GATE_ONE_OFS    = 12'h104; // Run gating, bank one
  localparam logic [11:0] RUN_GATE_TWO_OFS    = 12'h108; // Run gating, bank two
  localparam logic [11:0] SLEEP_GATE_ONE_OFS  = 12'h114; // Sleep gating, bank one
  localparam logic [11:0] DEEP_GATE_ONE_OFS   = 12'h124; // Deep-sleep gating, bank one
  localparam logic [11:0] RUN_CLOCK_CFG_OFS   = 12'h060; // Run clock configuration
  localparam logic [11:0] EVENT_STATUS_OFS    = 12'h200; // Sticky event status
  localparam logic [11:0] EVENT_MASK_OFS      = 12'h204; // Event mask

  // ----------------------------------------------------------------------
  // Field layout of the gating banks
  // ----------------------------------------------------------------------
  localparam int COMPARATOR_BIT   = 24;
  localparam int COUNTER_D_BIT    = 19;
  localparam int COUNTER_C_BIT    = 18;
  localparam int COUNTER_B_BIT    = 17;
  localparam int COUNTER_A_BIT    = 16;
  localparam int TWO_WIRE_2ND_BIT = 14;
  localparam int TWO_WIRE_1ST_BIT = 12;
  localparam int SYNC_SERIAL_BIT  = 4;
  localparam int ASYNC_SERIAL_BIT = 0;
  localparam int AUTO_GATE_BIT    = 27;        // Auto gate select in run clock config
  localparam int UNIT_COUNT       = 9;         // Gated units

  // Writable bits of banks one and two and of run clock config, then the gate reset value; everything else reads zero
  localparam logic [31:0] GATE_ONE_MASK = 32'h010F_5011;
  localparam logic [31:0] GATE_TWO_MASK = 32'h0000_201F;
  localparam logic [31:0] AUTO_GATE_MASK = 32'h0800_0000;
  localparam logic [31:0] GATE_RESET    = 32'h0000_0000;

  // Event status bits
  localparam int EVT_FAULT_BIT  = 0;           // Access to an unclocked unit
  localparam int EVT_CHANGE_BIT = 1;           // Selected gate set changed
  localparam logic [31:0] EVENT_MASK_BITS = 32'h0000_0003;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } power_mode_t;

endpackage : clock_gate_pkg

// *** unit_clock_gate.sv ***
// One glitch-free clock gate: a latch-free rising-edge enable flop, a falling-edge copy flop and an AND.
// Assumes the enable settles well before the rising edge; it is retimed here.
`timescale 1ns/10ps
module unit_clock_gate (
  input  wire logic clk,        // System clock
  input  wire logic reset_n,    // Synchronous reset, active low
  input  wire logic enable,     // Requested clock enable
  output logic      enableQ,    // Registered enable, also a status for bus fault check
  output logic      gatedClk    // Gated clock to the unit
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;                   // Enable taken at the rising edge
  } gate_state_t;

  gate_state_t state_q;
  gate_state_t state_d;
  logic        enLow_q;         // Low-phase copy, kept outside struct for negedge

  // Next state; the rising-edge flop carries the enable
  always_comb begin
    state_d       = state_q;
    state_d.en    = enable;
  end

  // Rising-edge register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Falling-edge copy so the AND only changes while clk is low
  always_ff @(negedge clk) begin
    if (!reset_n) begin
      enLow_q <= 1'b0;
    end else begin
      enLow_q <= state_q.en;
    end
  end

  assign gatedClk = clk & enLow_q;
  assign enableQ  = state_q.en;

endmodule : unit_clock_gate

// *** peripheral_clock_gating.sv ***
// Peripheral clock gating with run, sleep and deep-sleep gate banks on AHB-Lite.
// Assumes one system clock; the power mode comes from the power controller,
// and the unit select comes from the peripheral bus decoder.
//
// Summary of operation
// - Set bit clocks unit, clear stops it
// - Access to unclocked unit gets bus fault
// - All gating bits reset to zero
// - Three banks: run, sleep, deep sleep
// - Auto gate select enables low-power banks
// - Comparator bit 24, counters bits 19:16
// - Two-wire units at bits 14, 12
// - Sync serial bit 4, async bit 0
// - Reserved bits read-only, read zero
// - Sleep bank at offset 0x114
`timescale 1ns/10ps
module peripheral_clock_gating
  import clock_gate_pkg::*;
(
  input  wire logic                  clk,            // System clock, 125 MHz
  input  wire logic                  reset_n,        // Synchronous reset, active low
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [11:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Power mode and peripheral access check
  input  wire logic [1:0]            powerMode,      // power_mode_t code
  input  wire logic                  unitAccess,     // Peripheral access request
  input  wire logic [UNIT_COUNT-1:0] unitSelect,     // One-hot unit of that access
  output logic                       unitFault,      // Bus fault for that access
  // Gated clocks and enables
  output logic      [UNIT_COUNT-1:0] unitClk,        // Gated clocks
  output logic      [UNIT_COUNT-1:0] unitEnable,     // Unit enable, high while clocked
  output logic      [31:0]           gateTwoEnable,  // Bank two enables (not gated here)
  output logic                       irq             // Level interrupt
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] runOne;        // Run gating, bank one
    logic [31:0] runTwo;        // Run gating, bank two
    logic [31:0] sleepOne;      // Sleep gating, bank one
    logic [31:0] deepOne;       // Deep-sleep gating, bank one
    logic [31:0] runCfg;        // Run clock configuration
    logic [31:0] evtStatus;     // Sticky events
    logic [31:0] evtMask;       // Event mask
    logic [31:0] selected;      // Selected gate set last cycle
    logic        dataPhase;     // Pending data phase
    logic        dataWrite;     // Pending phase is a write
    logic [11:0] dataAddr;      // Pending address
    logic [31:0] rdata;         // Read data
    logic        fault;         // Unit access fault output
    logic        irq;           // Interrupt output
    logic [31:0] gateTwo;       // Registered bank two enable
  } regs_t;

  regs_t regs_q;
  regs_t regs_d;

  logic [31:0]           activeSet;    // Bank chosen for the present mode
  logic [UNIT_COUNT-1:0] unitReq;      // Per-unit enable request
  logic [UNIT_COUNT-1:0] unitEnQ;      // Per-unit retimed enable
  logic                  addrPhase;    // Valid address phase
  logic                  faultEvt;     // Fault this cycle
  logic                  changeEvt;    // Gate set changed this cycle
  logic [31:0]           wSet;         // Status clear bits on a write
  logic [31:0]           readMux;      // Read data for the address phase

  // Unit bit positions, comparator at the top
  localparam int UNIT_BIT [UNIT_COUNT] = '{COMPARATOR_BIT, COUNTER_D_BIT, COUNTER_C_BIT,
                                           COUNTER_B_BIT, COUNTER_A_BIT, TWO_WIRE_2ND_BIT,
                                           TWO_WIRE_1ST_BIT, SYNC_SERIAL_BIT,
                                           ASYNC_SERIAL_BIT};

  // ----------------------------------------------------------------------
  // Unit index map
  // ----------------------------------------------------------------------
  // Index 0 is the comparator, the last index the async serial unit;
  // the access decoder must one-hot unitSelect in this same order
  localparam int COMP_IDX     = 0;               // Comparator slot
  localparam int COUNTER_IDX  = 4;               // Counter a slot; d, c, b sit below it
  localparam int TWO_WIRE_IDX = 5;               // Second two-wire slot, first one above
  localparam int SYNC_IDX     = 7;               // Sync serial slot
  localparam int ASYNC_IDX    = UNIT_COUNT - 1;  // Async serial slot

  // ----------------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------------
  // bank per mode
  always_comb begin
    activeSet = regs_q.runOne;
    // low-power banks only with auto gate
    if (regs_q.runCfg[AUTO_GATE_BIT]) begin
      case (power_mode_t'(powerMode))
        MODE_RUN:   activeSet = regs_q.runOne;
        MODE_SLEEP: activeSet = regs_q.sleepOne;
        MODE_DEEP:  activeSet = regs_q.deepOne;
        default:    activeSet = regs_q.runOne;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < UNIT_COUNT; i++) begin
      unitReq[i] = activeSet[UNIT_BIT[i]];
    end
  end

  // ----------------------------------------------------------------------
  // Per-unit gates
  // ----------------------------------------------------------------------
  // Each gate retimes its enable, so a unit's clock follows its bit
  // a cycle and a half later; software must allow for that delay
  // one gate per unit
  for (genvar g = 0; g < UNIT_COUNT; g++) begin : gen_gate
    unit_clock_gate u_gate (
      .clk      (clk),
      .reset_n  (reset_n),
      .enable   (unitReq[g]),
      .enableQ  (unitEnQ[g]),
      .gatedClk (unitClk[g])
    );
  end

  assign unitEnable = unitEnQ;

  // ----------------------------------------------------------------------
  // Bus decode and events
  // ----------------------------------------------------------------------
  assign addrPhase = hsel & hready & htrans[1];
  // A read whose address phase overlaps the data phase of a write to the
  // same word returns the old value; leave one idle cycle between them
  // fault on unclocked access
  assign faultEvt  = unitAccess & |(unitSelect & ~unitEnQ);
  assign changeEvt = (activeSet != regs_q.selected);
  assign wSet      = (regs_q.dataPhase & regs_q.dataWrite
                     & (regs_q.dataAddr == EVENT_STATUS_OFS)) ? hwdata : '0;

  // Read mux; reserved bits already zero in storage
  always_comb begin
    case (haddr)
      RUN_GATE_ONE_OFS:   readMux = regs_q.runOne;
      RUN_GATE_TWO_OFS:   readMux = regs_q.runTwo;
      SLEEP_GATE_ONE_OFS: readMux = regs_q.sleepOne;
      DEEP_GATE_ONE_OFS:  readMux = regs_q.deepOne;
      RUN_CLOCK_CFG_OFS:  readMux = regs_q.runCfg;
      EVENT_STATUS_OFS:   readMux = regs_q.evtStatus;
      EVENT_MASK_OFS:     readMux = regs_q.evtMask;
      default:            readMux = '0;
    endcase
  end

  // Next state
  always_comb begin
    regs_d           = regs_q;
    regs_d.dataPhase = addrPhase;
    regs_d.dataWrite = hwrite;
    regs_d.dataAddr  = haddr;
    regs_d.selected  = activeSet;
    regs_d.fault     = faultEvt;
    regs_d.gateTwo   = regs_q.runTwo;
    if (addrPhase && !hwrite) begin
      regs_d.rdata = readMux;
    end
    // Writes land in the data phase
    if (regs_q.dataPhase && regs_q.dataWrite) begin
      case (regs_q.dataAddr)
        RUN_GATE_ONE_OFS:   regs_d.runOne   = hwdata & GATE_ONE_MASK;
        RUN_GATE_TWO_OFS:   regs_d.runTwo   = hwdata & GATE_TWO_MASK;
        SLEEP_GATE_ONE_OFS: regs_d.sleepOne = hwdata & GATE_ONE_MASK;
        DEEP_GATE_ONE_OFS:  regs_d.deepOne  = hwdata & GATE_ONE_MASK;
        RUN_CLOCK_CFG_OFS:  regs_d.runCfg   = hwdata & AUTO_GATE_MASK;
        EVENT_MASK_OFS:     regs_d.evtMask  = hwdata & EVENT_MASK_BITS;
        default:            regs_d.runOne   = regs_q.runOne;
      endcase
    end
    // Clear by writing one; a new event wins over the clear
    regs_d.evtStatus = regs_q.evtStatus & ~wSet;
    regs_d.evtStatus[EVT_FAULT_BIT]  = regs_d.evtStatus[EVT_FAULT_BIT] | faultEvt;
    regs_d.evtStatus[EVT_CHANGE_BIT] = regs_d.evtStatus[EVT_CHANGE_BIT] | changeEvt;
    regs_d.irq = |(regs_d.evtStatus & regs_d.evtMask);
  end

  // Register; all gates reset clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q          <= '0;
      regs_q.runOne   <= GATE_RESET;
      regs_q.sleepOne <= GATE_RESET;
      regs_q.deepOne  <= GATE_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  // Zero-wait OKAY slave
  assign hrdata        = regs_q.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign unitFault     = regs_q.fault;
  assign gateTwoEnable = regs_q.gateTwo;
  assign irq           = regs_q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All checks run on the system clock and rest while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_unit_follow: assert property (unitEnQ == $past(unitReq))
    else $error("unit enable does not follow request");

  a_fault_on_off: assert property (
    unitAccess && (unitSelect & ~unitEnable) != '0 |=> unitFault)
    else $error("no fault for unclocked access");
  a_no_fault: assert property (
    !unitAccess || (unitSelect & ~unitEnable) == '0 |=> !unitFault)
    else $error("fault without an unclocked access");
  // Set wins over a clear in the same cycle
  a_fault_sticky: assert property (faultEvt |=> regs_q.evtStatus[EVT_FAULT_BIT])
    else $error("fault event lost from status");

  a_reset_clear: assert property (
    $past(!reset_n) |-> regs_q.runOne == GATE_RESET && regs_q.sleepOne == GATE_RESET
                        && regs_q.deepOne == GATE_RESET && unitEnQ == '0)
    else $error("gates not clear after reset");

  // one bank per mode under auto gating
  a_run_pick: assert property (
    regs_q.runCfg[AUTO_GATE_BIT] && !(powerMode inside {MODE_SLEEP, MODE_DEEP})
    |-> activeSet == regs_q.runOne)
    else $error("run bank not selected");
  a_sleep_pick: assert property (
    regs_q.runCfg[AUTO_GATE_BIT] && powerMode == MODE_SLEEP |-> activeSet == regs_q.sleepOne)
    else $error("sleep bank not selected");
  a_deep_pick: assert property (
    regs_q.runCfg[AUTO_GATE_BIT] && powerMode == MODE_DEEP |-> activeSet == regs_q.deepOne)
    else $error("deep bank not selected");

  a_run_only: assert property (
    !regs_q.runCfg[AUTO_GATE_BIT] |-> activeSet == regs_q.runOne)
    else $error("low-power bank used without auto gate");

  a_comp_slot: assert property (
    unitEnQ[COMP_IDX] == $past(activeSet[COMPARATOR_BIT])
    && unitEnQ[COUNTER_IDX] == $past(activeSet[COUNTER_A_BIT]))
    else $error("comparator or counter slot wrong");
  a_two_wire_slot: assert property (
    unitEnQ[TWO_WIRE_IDX] == $past(activeSet[TWO_WIRE_2ND_BIT])
    && unitEnQ[TWO_WIRE_IDX + 1] == $past(activeSet[TWO_WIRE_1ST_BIT]))
    else $error("two-wire slot wrong");
  a_serial_slot: assert property (
    unitEnQ[SYNC_IDX] == $past(activeSet[SYNC_SERIAL_BIT])
    && unitEnQ[ASYNC_IDX] == $past(activeSet[ASYNC_SERIAL_BIT]))
    else $error("serial slot wrong");

  a_reserved_zero: assert property (
    (regs_q.runOne & ~GATE_ONE_MASK) == '0 && (regs_q.sleepOne & ~GATE_ONE_MASK) == '0
    && (regs_q.deepOne & ~GATE_ONE_MASK) == '0)
    else $error("reserved bit set");
  a_reserved_cfg: assert property (
    (regs_q.runTwo & ~GATE_TWO_MASK) == '0 && (regs_q.runCfg & ~AUTO_GATE_MASK) == '0)
    else $error("reserved configuration bit set");

  a_sleep_write: assert property (
    regs_q.dataPhase && regs_q.dataWrite && regs_q.dataAddr == SLEEP_GATE_ONE_OFS
    |=> regs_q.sleepOne == ($past(hwdata) & GATE_ONE_MASK))
    else $error("sleep bank write lost");

  // enables move only with the selected set
  a_gate_steady: assert property ($stable(activeSet) |=> $stable(unitEnQ))
    else $error("unit enable moved without a set change");

  // Interrupt level follows unmasked status
  a_irq_level: assert property (irq == |(regs_q.evtStatus & regs_q.evtMask))
    else $error("interrupt level wrong");

  // Main scenarios worth seeing at least once
  c_fault:  cover property (unitFault);
  c_deep:   cover property (regs_q.runCfg[AUTO_GATE_BIT] && powerMode == MODE_DEEP);
  c_sleep:  cover property (regs_q.runCfg[AUTO_GATE_BIT] && powerMode == MODE_SLEEP);
  c_irq:    cover property (irq);
  c_enable: cover property (unitEnQ[0] ##1 !unitEnQ[0]);

endmodule : peripheral_clock_gating

// *** peripheral_clock_gating_tb.sv ***
// Self-checking bench for the peripheral clock-gating block.
// Assumes clock_gate_pkg is compiled first; the bench is the only AHB-Lite master.
`timescale 1ns/10ps
module peripheral_clock_gating_tb;
  import clock_gate_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                  clk;            // 125 MHz system clock
  logic                  reset_n;        // Synchronous reset, active low
  logic                  hsel;           // Bus select
  logic [11:0]           haddr;          // Bus address
  logic [1:0]            htrans;         // Bus transfer type
  logic                  hwrite;         // Bus direction
  logic [2:0]            hsize;          // Always a whole word
  logic [31:0]           hwdata;         // Write data
  logic [31:0]           hrdata;         // Read data
  logic                  hreadyout;      // Slave ready, fed back as hready
  logic                  hresp;          // Slave response
  logic [1:0]            powerMode;      // Power mode code
  logic                  unitAccess;     // Peripheral access strobe
  logic [UNIT_COUNT-1:0] unitSelect;     // One-hot unit of the access
  logic                  unitFault;      // Fault answer
  logic [UNIT_COUNT-1:0] unitClk;        // Gated clocks
  logic [UNIT_COUNT-1:0] unitEnable;     // Unit enables
  logic [31:0]           gateTwoEnable;  // Bank two copy
  logic                  irq;            // Level interrupt
  int                    numErrors;      // Mismatch count
  int                    checksDone;     // Comparison count
  int                    cycles;         // Cycles for the hang guard
  logic [31:0]           bank [3];       // Model of run, sleep, deep banks
  logic                  autoGate;       // Model of the auto gate select bit
  logic [31:0]           rd;             // Last read data
  logic [11:0]           bankOfs [3];    // Offsets of the three bank-one registers
  peripheral_clock_gating DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .powerMode(powerMode),
    .unitAccess(unitAccess), .unitSelect(unitSelect), .unitFault(unitFault),
    .unitClk(unitClk), .unitEnable(unitEnable), .gateTwoEnable(gateTwoEnable), .irq(irq));
  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  always #4 clk = ~clk;
  // Budget is some 27 times the expected run of about 740 cycles, so a stuck wait cannot loop forever
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      numErrors++;
      printVerdict();
    end
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want) begin
      numErrors++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus
  // Bank word to unit order: index 0 comparator, 1..4 counters d..a,
  // 5 two-wire 2nd, 6 two-wire 1st, 7 sync serial, 8 async serial
  function automatic logic [UNIT_COUNT-1:0] unitMap(input logic [31:0] w);
    return {w[0], w[4], w[12], w[14], w[16], w[17], w[18], w[19], w[24]};
  endfunction : unitMap
  // Bank chosen by mode; low-power banks only when auto gating is on
  function automatic logic [UNIT_COUNT-1:0] expectEn();
    if (autoGate && powerMode == 2'h1) return unitMap(bank[1]);
    if (autoGate && powerMode == 2'h2) return unitMap(bank[2]);
    return unitMap(bank[0]);
  endfunction : expectEn
  // Enables one cycle after the change; gated clock seen in the high phase
  task automatic checkUnits();
    repeat (2) @(posedge clk);
    #1;
    check(32'(unitEnable), 32'(expectEn()));
    #2;
    check(32'(unitClk), 32'(expectEn()));
    @(posedge clk);
  endtask : checkUnits
  // Single closing point of the run
  task automatic printVerdict();
    if (numErrors == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : printVerdict
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] w;
    int          k;
    int          u;
    logic        flt;
    logic        m;
    clk = 1'b0; reset_n = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000; powerMode = 2'h0;
    unitAccess = 1'b0; unitSelect = '0; numErrors = 0; checksDone = 0; cycles = 0;
    bank = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    autoGate = 1'b0;
    bankOfs = '{RUN_GATE_ONE_OFS, SLEEP_GATE_ONE_OFS, DEEP_GATE_ONE_OFS};
    void'($urandom(32'h8d04));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (bankOfs[i]) begin
      bus(1'b0, bankOfs[i], 32'h0000_0000, rd);
      check(rd, GATE_RESET);
    end
    check(32'(unitEnable), 32'h0000_0000);
    // reserved bits drop writes, unmapped place reads zero
    foreach (bankOfs[i]) begin
      bus(1'b1, bankOfs[i], 32'hFFFF_FFFF, rd);
      bus(1'b0, bankOfs[i], 32'h0000_0000, rd);
      check(rd, GATE_ONE_MASK);
      bank[i] = GATE_ONE_MASK;
    end
    bus(1'b1, RUN_GATE_TWO_OFS, 32'hFFFF_FFFF, rd);
    bus(1'b0, RUN_GATE_TWO_OFS, 32'h0000_0000, rd);
    check(rd, GATE_TWO_MASK);
    check(gateTwoEnable, GATE_TWO_MASK);
    bus(1'b1, 12'h3FC, 32'hFFFF_FFFF, rd);
    bus(1'b0, 12'h3FC, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    // Unmapped place still completes OKAY
    check(32'(hresp), 32'h0000_0000);
    checkUnits();
    // Random bank contents, modes, faults and interrupt masking
    for (int n = 0; n < 30; n++) begin
      k = $urandom_range(2, 0);
      w = $urandom;
      bus(1'b1, bankOfs[k], w, rd);
      bank[k] = w & GATE_ONE_MASK;
      bus(1'b0, bankOfs[k], 32'h0000_0000, rd);
      check(rd, bank[k]);
      autoGate = ($urandom_range(1, 0) == 1);
      bus(1'b1, RUN_CLOCK_CFG_OFS, autoGate ? AUTO_GATE_MASK : 32'h0000_0000, rd);
      powerMode <= 2'($urandom_range(3, 0));
      checkUnits();
      m = ($urandom_range(1, 0) == 1);
      bus(1'b1, EVENT_MASK_OFS, {31'h0, m}, rd);
      bus(1'b1, EVENT_STATUS_OFS, EVENT_MASK_BITS, rd);
      u = $urandom_range(UNIT_COUNT - 1, 0);
      // a clocked unit must answer without a fault
      w = 32'(expectEn());
      flt = ~w[u];
      unitAccess <= 1'b1;
      unitSelect <= UNIT_COUNT'(1) << u;
      @(posedge clk);
      unitAccess <= 1'b0;
      #1;
      check(32'(unitFault), 32'(flt));
      @(posedge clk);
      #1;
      check(32'(irq), 32'(flt & m));
      @(posedge clk);
      bus(1'b0, EVENT_STATUS_OFS, 32'h0000_0000, rd);
      check(32'(rd[EVT_FAULT_BIT]), 32'(flt));
      bus(1'b1, EVENT_STATUS_OFS, 32'h0000_0001, rd);
      repeat (2) @(posedge clk);
      #1;
      check(32'(irq), 32'h0000_0000);
      @(posedge clk);
    end
    // second reset in mid-run clears every bank again
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (bankOfs[i]) begin
      bus(1'b0, bankOfs[i], 32'h0000_0000, rd);
      check(rd, GATE_RESET);
    end
    check(32'(unitEnable), 32'h0000_0000);
    printVerdict();
  end
endmodule : peripheral_clock_gating_tb
